/* bench/asd_host_model.sv */
// host microcontroller model on the register port
`timescale 1ns/100ps
module asd_host_model (
    input  wire logic               clk_sys,
    output asd_pkg::asd_host_t      host,
    input  wire logic [12:0]        rdata
);
    import asd_pkg::*;
    initial host = '0;
    // one request per call; the port takes it on the next edge
    task automatic reg_write(input logic [3:0] a, input logic [12:0] v);
        @(posedge clk_sys) host <= '{1'b1, 1'b0, a, v};
        @(posedge clk_sys) host <= '0;
    endtask : reg_write
    task automatic reg_read(input logic [3:0] a, output logic [12:0] v);
        @(posedge clk_sys) host <= '{1'b0, 1'b1, a, 13'h0};
        @(posedge clk_sys) host <= '0;
        @(posedge clk_sys) v = rdata;
    endtask : reg_read
endmodule : asd_host_model

/* bench/asd_regs_props.sv */
// port assertions for the register bank
`timescale 1ns/100ps
module asd_regs_props #(
    parameter int unsigned PATH_CYCLES = 32,
    parameter int unsigned RING_N      = 16
) (
    input wire logic                      clk_sys,
    input wire logic                      rst,
    input wire asd_pkg::asd_host_t        host,
    input wire asd_pkg::asd_mon_t         mon,
    input wire logic [11:0]               angle_in,
    input wire logic [12:0]               error_mask,
    input wire logic                      sent_selftest_req,
    input wire logic [12:0]               rdata,
    input wire logic                      serial_error,
    input wire logic                      spi_word_bit2,
    input wire logic                      extended_unlocked,
    input wire logic [$clog2(RING_N)-1:0] bias_element,
    input wire logic                      bias_enable
);
    import asd_pkg::*;
    localparam int PMIN = PATH_CYCLES - 2;
    localparam int PMAX = PATH_CYCLES + 2;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_rd(logic [3:0] a);
        $past(host.rd) && $past(host.addr) == a;
    endsequence
    sequence s_path_go;
        $rose(bias_enable) && bias_element == '0;
    endsequence
    a_rdata_idle: assert property (!$past(host.rd) |-> rdata == '0)
        else $error("rdata not idle");
    a_angle_read: assert property (
        s_rd(ADDR_ANGLE) ##0 $past(angle_in, 2) == $past(angle_in)
        |-> rdata == {$past(angle_in), 1'b0}) else $error("angle read wrong");
    a_key_hidden: assert property (s_rd(ADDR_KEY) |-> rdata == '0)
        else $error("key read not zero");
    a_err_spare: assert property (
        s_rd(ADDR_ERR_SEC) |-> (rdata & ~{6'h0, E2_USED}) == '0)
        else $error("spare error bits set");
    a_uv_bit: assert property ($rose(mon.undervoltage) |=> spi_word_bit2)
        else $error("undervoltage bit low");
    a_magnet_flag: assert property (mon.magnet_loss && error_mask == '0 |=> serial_error)
        else $error("magnet loss not flagged");
    a_flag_sticky: assert property (
        serial_error && !(host.wr && host.addr == ADDR_CTRL && host.wdata[C_ERR_CLEAR])
        |=> serial_error || $changed(error_mask)) else $error("error flag dropped");
    a_unlock_key: assert property ($rose(extended_unlocked) |->
        $past(host.wr && host.addr == ADDR_KEY && host.wdata[9:0] == KEY_DEFAULT))
        else $error("unlock without key");
    a_path_req: assert property (!bias_enable && (sent_selftest_req ||
        host.wr && host.addr == ADDR_CTRL && host.wdata[C_SELFTEST]) |=> bias_enable)
        else $error("path test not started");
    a_path_hold: assert property (s_path_go |-> bias_enable[*8])
        else $error("bias dropped early");
    a_path_len: assert property (s_path_go |-> ##[PMIN:PMAX] $fell(bias_enable))
        else $error("path test length wrong");
endmodule : asd_regs_props
bind asd_regs asd_regs_props #(.PATH_CYCLES(PATH_CYCLES), .RING_N(RING_N)) u_props (
    .clk_sys(clk_sys), .rst(rst), .host(host), .mon(mon), .angle_in(angle_in),
    .error_mask(error_mask), .sent_selftest_req(sent_selftest_req), .rdata(rdata),
    .serial_error(serial_error), .spi_word_bit2(spi_word_bit2),
    .extended_unlocked(extended_unlocked), .bias_element(bias_element),
    .bias_enable(bias_enable));

/* bench/tb_angle_sensor_diag_regs.sv */
// self-checking bench for the register bank
`timescale 1ns/100ps
module tb_angle_sensor_diag_regs;
    import asd_pkg::*;
    localparam int unsigned PC = 32;
    localparam int unsigned LC = 20;
    logic        clk_sys = 1'b0, rst = 1'b1, step_sel = 1'b1;
    logic        sent_req = 1'b0, lb_start = 1'b0, lb_fail = 1'b0, el_fail = 1'b0;
    asd_host_t   host;
    asd_mon_t    mon = '0;
    logic [11:0] angle_in = '0;
    logic [12:0] error_mask = '0, rdata, d;
    logic        serial_error, uv_bit, unlocked, busy, bias_en;
    logic [3:0]  bias_el, top;
    int          n_fail = 0, tests_run = 0, n, m;
    int          eb[7] = '{0, 2, 1, 4, 5, 6, 6};
    asd_host_model i_host (.clk_sys(clk_sys), .host(host), .rdata(rdata));
    asd_regs #(.PATH_CYCLES(PC), .LOGIC_CYCLES(LC), .RING_N(16)) i_asd_regs (
        .clk_sys(clk_sys), .rst(rst), .host(host), .mon(mon), .angle_in(angle_in),
        .count_step_select(step_sel), .error_mask(error_mask), .sent_selftest_req(sent_req),
        .logic_selftest_start(lb_start), .logic_selftest_fail(lb_fail),
        .path_element_fail(el_fail), .rdata(rdata), .serial_error(serial_error),
        .spi_word_bit2(uv_bit), .extended_unlocked(unlocked), .selftest_busy(busy),
        .bias_element(bias_el), .bias_enable(bias_en));
    initial forever #50 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        if (n_fail == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rd(input logic [3:0] a, input logic [12:0] e, input string nm);
        i_host.reg_read(a, d);
        chk(nm, e, d);
    endtask : rd
    task automatic clr;
        i_host.reg_write(ADDR_CTRL, 13'h001);
    endtask : clr
    task automatic pulse(input int b, input int k);
        repeat (k) begin
            @(posedge clk_sys) mon[b] <= 1'b1;
            @(posedge clk_sys) mon <= '0;
        end
    endtask : pulse
    // bounded wait; also notes the highest ring element biased
    task automatic wait_idle;
        int k;
        k = 0;
        top = '0;
        repeat (2) @(posedge clk_sys);
        while (busy !== 1'b0) begin
            if (bias_en === 1'b1 && bias_el > top) begin
                top = bias_el;
            end
            @(posedge clk_sys);
            k++;
            if (k > 300) begin
                n_fail++;
                finish_test();
            end
        end
    endtask : wait_idle
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(42542));
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        rd(ADDR_ERR_PRI, 13'h001, "primary err after reset");
        chk("serial flag", 13'h1, serial_error);
        clr();
        rd(ADDR_ERR_PRI, 13'h000, "primary err cleared");
        for (int i = 0; i < 7; i++) begin
            pulse(10 - i, 1);
            rd(ADDR_ERR_PRI + 4'(i / 6), 13'h1 << eb[i], "flag");
            chk("serial flag", 13'h1, serial_error);
            clr();
        end
        @(posedge clk_sys) error_mask <= '1;
        pulse(8, 1);
        rd(ADDR_ERR_PRI, 13'h002, "masked flag");
        chk("serial masked", 13'h0, serial_error);
        clr();
        @(posedge clk_sys) error_mask <= '0;
        mon.undervoltage <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk("uv bit", 13'h1, uv_bit);
        @(posedge clk_sys) mon <= '0;
        for (int i = 0; i < 5; i++) begin
            n = (i == 0) ? 4095 : $urandom_range(4095, 0);
            @(posedge clk_sys) angle_in <= 12'(n);
            rd(ADDR_ANGLE, {12'(n), 1'b0}, "angle");
        end
        n = $urandom_range(9, 1);
        m = $urandom_range(n + 3, 0);
        i_host.reg_write(ADDR_CTRL, 13'h00a);
        pulse(2, n);
        pulse(1, m);
        rd(ADDR_TURNS, {1'b0, 12'(n - m)}, "turns 45");
        // one step past the positive limit raises the overflow flag
        i_host.reg_write(ADDR_CTRL, 13'h00a);
        pulse(2, 1281);
        rd(ADDR_ERR_PRI, 13'h008, "turns overflow");
        chk("serial overflow", 13'h1, serial_error);
        clr();
        @(posedge clk_sys) step_sel <= 1'b0;
        i_host.reg_write(ADDR_CTRL, 13'h00a);
        pulse(1, 8);
        rd(ADDR_TURNS, 13'h0ffe, "turns 180");
        i_host.reg_write(ADDR_CTRL, 13'h1fe6);
        rd(ADDR_CTRL, 13'h006, "ctrl readback");
        i_host.reg_write(ADDR_KEY, 13'h0aa);
        rd(ADDR_KEY, 13'h000, "key read");
        chk("locked", 13'h0, unlocked);
        i_host.reg_write(ADDR_KEY, {3'h0, KEY_DEFAULT});
        rd(4'h3, 13'h000, "unmapped read");
        chk("unlocked", 13'h1, unlocked);
        for (int f = 0; f < 2; f++) begin
            @(posedge clk_sys) el_fail <= f[0];
            if (f == 0) begin
                @(posedge clk_sys) sent_req <= 1'b1;
                @(posedge clk_sys) sent_req <= 1'b0;
            end else begin
                i_host.reg_write(ADDR_CTRL, 13'h010);
            end
            wait_idle();
            chk("ring top", 13'h00f, 13'(top));
            @(posedge clk_sys) el_fail <= 1'b0;
            rd(ADDR_ERR_SEC, 13'(f) << 3, "path result");
            chk("serial path", 13'(f), serial_error);
            clr();
        end
        for (int f = 1; f >= 0; f--) begin
            @(posedge clk_sys) lb_start <= 1'b1;
            lb_fail <= f[0];
            @(posedge clk_sys) lb_start <= 1'b0;
            repeat (LC + 5) @(posedge clk_sys);
            wait_idle();
            rd(ADDR_ERR_SEC, 13'(f) << 4, "logic result");
            clr();
        end
        // hard reset in mid-run brings back the power-loss flag
        @(posedge clk_sys) rst <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        rd(ADDR_ERR_PRI, 13'h001, "primary err after second reset");
        chk("serial after reset", 13'h1, serial_error);
        rd(ADDR_TURNS, 13'h000, "turns after reset");
        finish_test();
    end
endmodule : tb_angle_sensor_diag_regs

/* rtl/asd_pkg.sv */
// package for the angle sensor diagnostic register bank
package asd_pkg;
    localparam int unsigned     REG_W          = 13;
    localparam int unsigned     ADDR_W         = 4;
    localparam logic [3:0]      ADDR_ANGLE     = 4'h0;
    localparam logic [3:0]      ADDR_TURNS     = 4'h2;
    localparam logic [3:0]      ADDR_ERR_PRI   = 4'h4;
    localparam logic [3:0]      ADDR_ERR_SEC   = 4'h5;
    localparam logic [3:0]      ADDR_CTRL      = 4'h8;
    localparam logic [3:0]      ADDR_KEY       = 4'hf;
    // primary error field positions
    localparam int unsigned     E1_POWER       = 0;
    localparam int unsigned     E1_MAGNET      = 1;
    localparam int unsigned     E1_INTERNAL    = 2;
    localparam int unsigned     E1_TURNS_OVF   = 3;
    localparam int unsigned     E1_TEMP        = 4;
    localparam int unsigned     E1_MEM_SINGLE  = 5;
    localparam int unsigned     E1_MEM_DOUBLE  = 6;
    localparam int unsigned     E1_BITS        = 7;
    localparam logic [6:0]      E1_RESET       = 7'h01;
    // secondary error field positions
    localparam int unsigned     E2_PATH_FAIL   = 3;
    localparam int unsigned     E2_LOGIC_FAIL  = 4;
    localparam int unsigned     E2_LINE_CODE   = 6;
    localparam logic [6:0]      E2_USED        = 7'h58;
    localparam logic [6:0]      E2_RESET       = 7'h00;
    // control field positions
    localparam int unsigned     C_ERR_CLEAR    = 0;
    localparam int unsigned     C_TURNS_EN     = 1;
    localparam int unsigned     C_RPM          = 2;
    localparam int unsigned     C_TURNS_RST    = 3;
    localparam int unsigned     C_SELFTEST     = 4;
    localparam logic [4:0]      CTRL_RESET     = 5'h00;
    localparam logic [9:0]      KEY_DEFAULT    = 10'h155;
    localparam int unsigned     KEY_W          = 10;
    // timing
    localparam int unsigned     CLK_HZ         = 10_000_000;
    localparam int unsigned     LOGIC_ST_MS    = 10;
    localparam int unsigned     LOGIC_ST_CNT   = CLK_HZ / 1000 * LOGIC_ST_MS;
    localparam int unsigned     PATH_ST_CYCLES = 1000;
    localparam int unsigned     RING_ELEMENTS  = 16;
    localparam logic [11:0]     TURNS_LIMIT    = 12'h500;

    typedef enum logic [1:0] {
        ASD_IDLE,
        ASD_LOGIC_TEST,
        ASD_PATH_TEST
    } asd_test_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [12:0] wdata;
    } asd_host_t;

    typedef struct packed {
        logic power_loss;
        logic internal_logic_error;
        logic magnet_loss;
        logic temperature_out_of_range;
        logic memory_single_bit_corrected;
        logic memory_double_bit_error;
        logic supply_line_coding_error;
        logic undervoltage;
        logic turn_cw;
        logic turn_ccw;
        logic quarter_step;
    } asd_mon_t;
endpackage : asd_pkg

/* rtl/asd_regs.sv */
// primary host registers and diagnostic flags of one sensor die
`timescale 1ns/100ps

// How it works
// [R1] logic self-test end records pass or fail flag readable in error registers
// [R2] logic self-test runs 10 ms; failures flag in second error register
// [R3] path self-test starts on request from SPI control bit or SENT request
// [R4] path self-test biases each ring element in turn, angle per element
// [R5] incremental angles of one ring pass stored; pass ends in fixed time
// [R6] path self-test failure sets second-register flag, seen on serial flag
// [R7] angle register: 12-bit angle in bits 12:1, bit 0 zero
// [R8] turns register returns accumulated count in bits 11:0
// [R9] both error registers readable and show current flags
// [R10] control register readable and writable by host
// [R11] extended access blocked until correct key code written
// [R12] supply loss sets power-loss flag
// [R13] internal logic monitor malfunction sets internal-error flag
// [R14] low field sets magnet-loss flag
// [R15] memory single and double bit events set their flags
// [R16] undervoltage drives bit 2 of SPI output word high
// [R17] temperature out of range sets its flag
// [R18] error bits sticky until error-clear write or reset
// [R19] unmasked set error bit raises serial error flag; masked ones do not
// [R20] turns count two's complement, step 180 or 45 degrees by select
// [R21] power-loss flag set after reset, must be cleared by host
// [R22] reserved bits read zero, writes ignored
module asd_regs #(
    parameter int unsigned PATH_CYCLES  = asd_pkg::PATH_ST_CYCLES,
    parameter int unsigned LOGIC_CYCLES = asd_pkg::LOGIC_ST_CNT,
    parameter int unsigned RING_N       = asd_pkg::RING_ELEMENTS
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    input  wire asd_pkg::asd_host_t   host,
    input  wire asd_pkg::asd_mon_t    mon,
    input  wire logic [11:0]          angle_in,
    input  wire logic                 count_step_select,
    input  wire logic [12:0]          error_mask,
    input  wire logic                 sent_selftest_req,
    input  wire logic                 logic_selftest_start,
    input  wire logic                 logic_selftest_fail,
    input  wire logic                 path_element_fail,
    output logic [12:0]               rdata,
    output logic                      serial_error,
    output logic                      spi_word_bit2,
    output logic                      extended_unlocked,
    output logic                      selftest_busy,
    output logic [$clog2(RING_N)-1:0] bias_element,
    output logic                      bias_enable
);
    import asd_pkg::*;

    // refused at elaboration, before any logic is built
    if (RING_N < 2 || PATH_CYCLES < RING_N || LOGIC_CYCLES < 1) begin : g_bad_params
        $error("asd_regs: unsupported parameters");
    end

    localparam int unsigned EW = $clog2(RING_N);
    localparam int unsigned SLOT = PATH_CYCLES / RING_N;
    localparam int unsigned CW = $clog2(LOGIC_CYCLES + PATH_CYCLES + 1);

    typedef struct packed {
        logic [11:0]      angle;
        logic [11:0]      turns;
        logic [1:0]       quarter;
        logic [6:0]       err_pri;
        logic [6:0]       err_sec;
        logic [4:0]       ctrl;
        logic             unlocked;
        asd_test_t        test;
        logic [CW-1:0]    cnt;
        logic [EW-1:0]    elem;
        logic             path_bad;
        logic [12:0]      rdata;
        logic             uv;
    } asd_state_t;

    asd_state_t st_reg, st_next;
    logic [11:0] ring_store [RING_N];

    function automatic logic [11:0] step_turns(input logic [11:0] t, input logic up);
        step_turns = up ? t + 12'h001 : t - 12'h001;
    endfunction : step_turns

    ////////////////////////////////////////////////////////////////////////
    logic        clr;
    logic        step_up;
    logic        step_dn;
    logic        path_req;
    logic [12:0] err_view;
    logic        slot_end;

    always_comb begin
        st_next = st_reg;
        clr = host.wr && host.addr == ADDR_CTRL && host.wdata[C_ERR_CLEAR];
        path_req = (host.wr && host.addr == ADDR_CTRL && host.wdata[C_SELFTEST])
                   || sent_selftest_req;                                   // [R3]
        slot_end = st_reg.cnt == CW'(SLOT - 1);
        st_next.angle = angle_in;
        st_next.uv = mon.undervoltage;                                     // [R16]

        // turns stepping: coarse 180 degree steps only on every 4th quarter
        step_up = 1'b0;
        step_dn = 1'b0;
        if (st_reg.ctrl[C_TURNS_EN] && (mon.turn_cw || mon.turn_ccw)) begin
            if (count_step_select) begin                                   // [R20]
                step_up = mon.turn_cw;
                step_dn = mon.turn_ccw;
            end else begin
                st_next.quarter = mon.turn_cw ? st_reg.quarter + 2'd1
                                              : st_reg.quarter - 2'd1;
                step_up = mon.turn_cw && st_reg.quarter == 2'd3;
                step_dn = mon.turn_ccw && st_reg.quarter == 2'd0;
            end
        end
        if (step_up || step_dn)
            st_next.turns = step_turns(st_reg.turns, step_up);             // [R20]

        // sticky flags: clear first, then sets win
        if (clr) begin                                                     // [R18]
            st_next.err_pri = '0;
            st_next.err_sec = '0;
        end
        if (mon.power_loss)
            st_next.err_pri[E1_POWER] = 1'b1;                              // [R12]
        if (mon.magnet_loss)
            st_next.err_pri[E1_MAGNET] = 1'b1;                             // [R14]
        if (mon.internal_logic_error)
            st_next.err_pri[E1_INTERNAL] = 1'b1;                           // [R13]
        if (mon.temperature_out_of_range)
            st_next.err_pri[E1_TEMP] = 1'b1;                               // [R17]
        if (mon.memory_single_bit_corrected)
            st_next.err_pri[E1_MEM_SINGLE] = 1'b1;                         // [R15]
        if (mon.memory_double_bit_error)
            st_next.err_pri[E1_MEM_DOUBLE] = 1'b1;                         // [R15]
        if ((step_up && st_reg.turns == TURNS_LIMIT)
            || (step_dn && st_reg.turns == 12'(-TURNS_LIMIT)))
            st_next.err_pri[E1_TURNS_OVF] = 1'b1;                          // [R20]
        if (mon.supply_line_coding_error)
            st_next.err_sec[E2_LINE_CODE] = 1'b1;

        // control and key
        if (host.wr && host.addr == ADDR_CTRL)
            st_next.ctrl = {1'b0, host.wdata[C_TURNS_RST:C_TURNS_EN], 1'b0}; // [R10]
        if (host.wr && host.addr == ADDR_CTRL && host.wdata[C_TURNS_RST]) begin
            st_next.turns = '0;
            st_next.quarter = '0;
            st_next.ctrl[C_TURNS_RST] = 1'b0;
        end
        if (host.wr && host.addr == ADDR_KEY)
            st_next.unlocked = host.wdata[KEY_W-1:0] == KEY_DEFAULT;       // [R11]

        // self-test sequencer
        case (st_reg.test)
            ASD_IDLE: begin
                st_next.cnt = '0;
                if (logic_selftest_start) begin
                    st_next.test = ASD_LOGIC_TEST;
                end else if (path_req) begin
                    st_next.test = ASD_PATH_TEST;                          // [R3]
                    st_next.elem = '0;
                    st_next.path_bad = 1'b0;
                end
            end
            ASD_LOGIC_TEST: begin
                st_next.cnt = st_reg.cnt + CW'(1);
                if (st_reg.cnt == CW'(LOGIC_CYCLES - 1)) begin             // [R2]
                    st_next.test = ASD_IDLE;
                    if (logic_selftest_fail)
                        st_next.err_sec[E2_LOGIC_FAIL] = 1'b1;             // [R1]
                end
            end
            ASD_PATH_TEST: begin
                st_next.cnt = slot_end ? '0 : st_reg.cnt + CW'(1);
                if (path_element_fail)
                    st_next.path_bad = 1'b1;
                if (slot_end) begin                                        // [R4]
                    st_next.elem = st_reg.elem + EW'(1);
                    if (st_reg.elem == EW'(RING_N - 1)) begin              // [R5]
                        st_next.test = ASD_IDLE;
                        if (st_reg.path_bad || path_element_fail)
                            st_next.err_sec[E2_PATH_FAIL] = 1'b1;          // [R6]
                    end
                end
            end
            default: st_next.test = ASD_IDLE;
        endcase

        // read mux, reserved bits zero
        st_next.rdata = '0;                                                // [R22]
        if (host.rd) begin
            if (host.addr == ADDR_ANGLE)
                st_next.rdata = {st_reg.angle, 1'b0};                      // [R7]
            else if (host.addr == ADDR_TURNS)
                st_next.rdata = {1'b0, st_reg.turns};                      // [R8]
            else if (host.addr == ADDR_ERR_PRI)
                st_next.rdata = {6'h00, st_reg.err_pri};                   // [R9]
            else if (host.addr == ADDR_ERR_SEC)
                st_next.rdata = {6'h00, st_reg.err_sec & E2_USED};         // [R9]
            else if (host.addr == ADDR_CTRL)
                st_next.rdata = {8'h00, st_reg.test != ASD_IDLE,
                                 st_reg.ctrl[C_TURNS_RST:C_TURNS_EN], 1'b0}; // [R10]
        end
    end

    // ring angles kept out of the state struct; array keeps it readable
    always_ff @(posedge clk_sys) begin
        if (st_reg.test == ASD_PATH_TEST && slot_end)
            ring_store[st_reg.elem] <= angle_in;                           // [R5]
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_reg <= '{angle: '0, turns: '0, quarter: '0, err_pri: E1_RESET, // [R21]
                        err_sec: E2_RESET, ctrl: CTRL_RESET, unlocked: 1'b0,
                        test: ASD_IDLE, cnt: '0, elem: '0, path_bad: 1'b0,
                        rdata: '0, uv: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign err_view          = {6'h00, st_reg.err_pri} | {6'h00, st_reg.err_sec & E2_USED};
    assign serial_error      = |(err_view & ~error_mask);                  // [R19]
    assign spi_word_bit2     = st_reg.uv;                                  // [R16]
    assign rdata             = st_reg.rdata;
    assign extended_unlocked = st_reg.unlocked;                            // [R11]
    assign selftest_busy     = st_reg.test != ASD_IDLE;
    assign bias_element      = st_reg.elem;
    assign bias_enable       = st_reg.test == ASD_PATH_TEST;               // [R4]
endmodule : asd_regs
